// file: logic/acf_conv_if.sv
`timescale 1ns/1ns
`default_nettype none
// links the converter sequencer to the result formatter
interface acf_conv_if;
   logic       done;
   logic [9:0] code;
   logic       low_read;
   logic       high_read;
   logic       locked;
   modport seq (output done, output code, input locked);
   modport fmt (input done, input code, input low_read, input high_read, output locked);
   modport bus (output low_read, output high_read);
endinterface
`default_nettype wire

// file: logic/acf_pkg.sv
package acf_pkg;
   typedef enum logic [1:0] {
      acf_ref_pin,
      acf_ref_supply,
      acf_ref_reserved,
      acf_ref_internal
   } acf_ref_type;

   typedef enum logic [1:0] {
      acf_gain_1x,
      acf_gain_10x,
      acf_gain_200x
   } acf_gain_type;
endpackage

// file: logic/acf_regs.svh
// What this block does
// - single-ended result is unsigned 10-bit code
// - differential result is 10-bit two's complement
// - result bit 9 marks negative differential
// - bits 7:6 pick reference source
// - selection changes wait for conversion end
// - bit 5 left adjusts the result
// - left adjust change shows at once
// - codes 0-7 single-ended, 30 bandgap, 31 ground
// - codes 8-15 select gained differential pairs
// - codes 16-29 select unity-gain differential pairs
// - result readable once done flag is high
// - adjusted byte layout of result registers
// - low byte read locks result until high read
// - done flag set when result registers updated
`ifndef ACF_REGS_SVH
`define ACF_REGS_SVH
`define ACF_OFS_SELECT     8'h00
`define ACF_OFS_RES_LOW    8'h04
`define ACF_OFS_RES_HIGH   8'h08
`define ACF_OFS_CONTROL    8'h0c
`define ACF_OFS_STATUS     8'h10
`define ACF_OFS_MASK       8'h14
`define ACF_SELECT_RESET   8'h00
`define ACF_REF_MSB        7
`define ACF_REF_LSB        6
`define ACF_LADJ_BIT       5
`define ACF_CHAN_MSB       4
`define ACF_CHAN_LSB       0
`define ACF_CTRL_START_BIT 0
`define ACF_ST_DONE_BIT    0
`define ACF_ST_BUSY_BIT    1
`define ACF_DIFF_GAIN_LO   5'h08
`define ACF_DIFF_GAIN_HI   5'h0f
`define ACF_DIFF_N1_LO     5'h10
`define ACF_DIFF_N1_HI     5'h17
`define ACF_DIFF_N2_LO     5'h18
`define ACF_DIFF_N2_HI     5'h1d
`define ACF_CODE_BANDGAP   5'h1e
`define ACF_CODE_GROUND    5'h1f
`define ACF_RESP_OKAY      2'b00
`define ACF_RESP_SLVERR    2'b10
`endif

// file: logic/acf_result_fmt.sv
`timescale 1ns/1ns
`default_nettype none
`include "acf_regs.svh"
module acf_result_fmt (
   // clock and reset
   input  wire logic aclk,
   input  wire logic aresetn,
   // conversion side
   acf_conv_if.fmt   conv,
   // presentation
   input  wire logic left_adjust,
   output logic [7:0] result_low_byte,
   output logic [7:0] result_high_byte
);
   logic [9:0] result;
   logic       lock;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         result <= 10'h000;
         lock   <= 1'b0;
      end else begin
         if (conv.done && !lock)
            result <= conv.code;
         if (conv.high_read)
            lock <= 1'b0;
         else if (conv.low_read)
            lock <= 1'b1;
      end
   end

   // a low read in the very cycle of completion must hold off the update too
   assign conv.locked = lock || conv.low_read;
   // layout follows the live left_adjust bit
   assign result_high_byte = left_adjust ? result[9:2] : {6'h00, result[9:8]};
   assign result_low_byte  = left_adjust ? {result[1:0], 6'h00} : result[7:0];
endmodule
`default_nettype wire

// file: logic/acf_sequencer.sv
`timescale 1ns/1ns
`default_nettype none
module acf_sequencer #(
   parameter int CONV_CYCLES = 13
) (
   // clock and reset
   input  wire logic aclk,
   input  wire logic aresetn,
   // control
   input  wire logic start,
   output logic      busy,
   output logic      capture,
   // analog converter
   input  wire logic [9:0] sample_code,
   acf_conv_if.seq   conv
);
   typedef enum logic [1:0] {acf_idle, acf_conv, acf_wait} acf_seq_type;
   acf_seq_type state;
   logic [7:0]  count;
   logic [9:0]  code;

   assign busy    = (state != acf_idle);
   assign capture = (state == acf_idle) && start;
   assign conv.code = code;
   assign conv.done = (state == acf_wait) && !conv.locked;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state <= acf_idle;
         count <= 8'h00;
         code  <= 10'h000;
      end else begin
         unique case (state)
            acf_idle: if (start) begin
               state <= acf_conv;
               count <= 8'(CONV_CYCLES - 1);
            end
            acf_conv: begin
               if (count == 8'h00) begin
                  code  <= sample_code;
                  state <= acf_wait;
               end else
                  count <= count - 8'h01;
            end
            acf_wait: if (!conv.locked) state <= acf_idle;
         endcase
      end
   end
endmodule
`default_nettype wire

// file: logic/acf_top.sv
// The implementer's own choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
`include "acf_regs.svh"
module acf_top #(
   parameter int CONV_CYCLES = 13
) (
   // clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // axi4-lite write
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // axi4-lite read
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // analog front end
   input  wire logic [9:0]  sample_code,
   output logic [2:0]       pos_input,
   output logic [2:0]       neg_input,
   output logic             diff_mode,
   output logic [1:0]       gain_sel,
   output logic             bandgap_sel,
   output logic             ground_sel,
   output logic [1:0]       reference_select,
   // interrupt
   output logic             irq
);
   acf_conv_if conv ();

   logic [7:0] converter_input_select;
   logic [7:0] shadow_sel;
   logic       start;
   logic       busy;
   logic       capture;
   logic [1:0] status;
   logic [1:0] mask;
   logic [7:0] res_low;
   logic [7:0] res_high;
   logic       aw_held;
   logic       w_held;
   logic [7:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;

   // decode of the shadowed selection
   function automatic logic [8:0] acf_decode(input logic [4:0] c);
      logic [2:0] p;
      logic [2:0] n;
      logic       d;
      logic [1:0] g;
      p = c[2:0];
      n = 3'h0;
      d = 1'b0;
      g = 2'(acf_pkg::acf_gain_1x);
      if (c >= `ACF_DIFF_GAIN_LO && c <= `ACF_DIFF_GAIN_HI) begin
         d = 1'b1;
         p = {1'b0, c[2], c[0]};
         n = {1'b0, c[2], 1'b0};
         g = c[1] ? 2'(acf_pkg::acf_gain_200x) : 2'(acf_pkg::acf_gain_10x);
      end else if (c >= `ACF_DIFF_N1_LO && c <= `ACF_DIFF_N1_HI) begin
         d = 1'b1;
         n = 3'h1;
      end else if (c >= `ACF_DIFF_N2_LO && c <= `ACF_DIFF_N2_HI) begin
         d = 1'b1;
         n = 3'h2;
      end
      return {d, g, n, p};
   endfunction

   wire [8:0] dec        = acf_decode(shadow_sel[`ACF_CHAN_MSB:`ACF_CHAN_LSB]);
   wire [4:0] chan       = shadow_sel[`ACF_CHAN_MSB:`ACF_CHAN_LSB];
   wire       wr_fire    = aw_held && w_held && !s_axi_bvalid;
   wire       rd_fire    = s_axi_arvalid && s_axi_arready;
   wire       aw_take    = s_axi_awvalid && s_axi_awready;
   wire       w_take     = s_axi_wvalid && s_axi_wready;
   wire       wr_sel     = wr_fire && aw_addr == `ACF_OFS_SELECT && w_strb[0];
   wire       wr_ctrl    = wr_fire && aw_addr == `ACF_OFS_CONTROL && w_strb[0];
   wire       wr_mask    = wr_fire && aw_addr == `ACF_OFS_MASK && w_strb[0];
   wire       wr_known   = aw_addr == `ACF_OFS_SELECT || aw_addr == `ACF_OFS_CONTROL
                           || aw_addr == `ACF_OFS_MASK;
   wire       rd_known   = s_axi_araddr <= `ACF_OFS_MASK && s_axi_araddr[1:0] == 2'b00;
   wire       rd_low     = rd_fire && s_axi_araddr == `ACF_OFS_RES_LOW;
   wire       rd_high    = rd_fire && s_axi_araddr == `ACF_OFS_RES_HIGH;
   wire       rd_status  = rd_fire && s_axi_araddr == `ACF_OFS_STATUS;
   wire [1:0] events     = {1'b0, conv.done};
   wire [7:0] rd_word    =
      s_axi_araddr == `ACF_OFS_SELECT  ? converter_input_select :
      s_axi_araddr == `ACF_OFS_RES_LOW ? res_low :
      s_axi_araddr == `ACF_OFS_RES_HIGH ? res_high :
      s_axi_araddr == `ACF_OFS_CONTROL ? {7'h00, busy} :
      s_axi_araddr == `ACF_OFS_STATUS  ? {6'h00, busy, status[`ACF_ST_DONE_BIT]} :
      s_axi_araddr == `ACF_OFS_MASK    ? {6'h00, mask} : 8'h00;

   assign conv.low_read  = rd_low;
   assign conv.high_read = rd_high;

   acf_sequencer #(
      .CONV_CYCLES (CONV_CYCLES)
   ) u_seq (
      .aclk        (aclk),
      .aresetn     (aresetn),
      .start       (start),
      .busy        (busy),
      .capture     (capture),
      .sample_code (sample_code),
      .conv        (conv.seq)
   );

   acf_result_fmt u_fmt (
      .aclk             (aclk),
      .aresetn          (aresetn),
      .conv             (conv.fmt),
      .left_adjust      (converter_input_select[`ACF_LADJ_BIT]),
      .result_low_byte  (res_low),
      .result_high_byte (res_high)
   );

   // register and selection state
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         converter_input_select <= `ACF_SELECT_RESET;
         shadow_sel <= `ACF_SELECT_RESET;
         start      <= 1'b0;
         mask       <= 2'b00;
         status     <= 2'b00;
      end else begin
         if (wr_sel)
            converter_input_select <= w_data[7:0];
         // new selections reach the front end only between conversions
         if (capture)
            shadow_sel <= converter_input_select;
         start <= wr_ctrl ? w_data[`ACF_CTRL_START_BIT] : (start && !capture);
         if (wr_mask)
            mask <= w_data[1:0];
         // set beats read-clear
         status <= (rd_status ? 2'b00 : status) | events;
      end
   end

   // analog front end outputs and interrupt, all registered
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pos_input <= 3'h0;
         neg_input <= 3'h0;
         diff_mode <= 1'b0;
         gain_sel  <= 2'b00;
         bandgap_sel <= 1'b0;
         ground_sel  <= 1'b0;
         reference_select <= 2'b00;
         irq <= 1'b0;
      end else begin
         pos_input <= dec[2:0];
         neg_input <= dec[5:3];
         gain_sel  <= dec[7:6];
         diff_mode <= dec[8];
         bandgap_sel <= chan == `ACF_CODE_BANDGAP;
         ground_sel  <= chan == `ACF_CODE_GROUND;
         reference_select <= shadow_sel[`ACF_REF_MSB:`ACF_REF_LSB];
         irq <= |(((rd_status ? 2'b00 : status) | events) & mask);
      end
   end

   // axi4-lite slave
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         w_held  <= 1'b0;
         aw_addr <= 8'h00;
         w_data  <= 32'h0000_0000;
         w_strb  <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `ACF_RESP_OKAY;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= `ACF_RESP_OKAY;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_arready <= 1'b0;
      end else begin
         // ready flags are the next free state of each slot
         s_axi_awready <= wr_fire || !(aw_held || aw_take);
         s_axi_wready  <= wr_fire || !(w_held || w_take);
         s_axi_arready <= !(rd_fire || (s_axi_rvalid && !s_axi_rready));
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (wr_fire) begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_known ? `ACF_RESP_OKAY : `ACF_RESP_SLVERR;
         end else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
         if (rd_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= {24'h000000, rd_word};
            s_axi_rresp  <= rd_known ? `ACF_RESP_OKAY : `ACF_RESP_SLVERR;
         end else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

endmodule
`default_nettype wire

// file: testbench/acf_analog_model.sv
`timescale 1ns/1ns
`default_nettype none
module acf_analog_model (
   // selection from the block
   input wire logic [2:0]       pos_input,
   input wire logic [2:0]       neg_input,
   input wire logic             diff_mode,
   input wire logic [1:0]       gain_sel,
   input wire logic             bandgap_sel,
   input wire logic             ground_sel,
   input wire logic [1:0]       reference_select,
   // pin voltages in millivolts
   input wire logic [7:0][10:0] vin,
   // converter code
   output logic [9:0]           sample_code
);
   int vref;
   int g;
   int d;
   // reference pin carries an outside 2000 mV source
   always_comb begin
      vref = reference_select == 2'b00 ? 2000 : reference_select == 2'b01 ? 3300 : 2560;
      g = gain_sel == 2'd2 ? 200 : gain_sel == 2'd1 ? 10 : 1;
      d = diff_mode ? (int'(vin[pos_input]) - int'(vin[neg_input])) * g * 512 / vref
                    : int'(vin[pos_input]) * 1024 / vref;
      if (diff_mode) begin
         d = d > 511 ? 511 : d < -512 ? -512 : d;
      end else begin
         d = d > 1023 ? 1023 : d;
      end
      if (ground_sel) begin
         d = 0;
      end else if (bandgap_sel) begin
         d = 1230 * 1024 / vref;
      end
      sample_code = 10'(d);
   end
endmodule
`default_nettype wire

// file: testbench/acf_top_props.sv
`timescale 1ns/1ns
`default_nettype none
module acf_top_props #(
   parameter int CONV_CYCLES = 13
) (
   // clock and reset
   input wire logic        aclk,
   input wire logic        aresetn,
   // register bus
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [7:0]  s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   // front end and interrupt
   input wire logic        diff_mode,
   input wire logic [1:0]  gain_sel,
   input wire logic        bandgap_sel,
   input wire logic        ground_sel,
   input wire logic        irq
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   chk_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   chk_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped");
   chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##[1:3] s_axi_bvalid)
      else $error("write answer late");
   chk_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while answer pending");
   chk_unmapped_err: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h18
      |=> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0)
      else $error("unmapped read not refused");
   chk_ground_alone: assert property (ground_sel |-> !bandgap_sel && !diff_mode)
      else $error("ground selection not exclusive");
   chk_gain_legal: assert property (gain_sel != 2'b11)
      else $error("gain code undefined");
   chk_reset_quiet: assert property (disable iff (1'b0) !aresetn |=> !irq && !s_axi_rvalid)
      else $error("outputs active after reset");
endmodule
bind acf_top acf_top_props #(.CONV_CYCLES(CONV_CYCLES)) u_acf_top_props (.aclk(aclk),
   .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .diff_mode(diff_mode),
   .gain_sel(gain_sel), .bandgap_sel(bandgap_sel), .ground_sel(ground_sel), .irq(irq));
`default_nettype wire

// file: testbench/testbench.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_errors++; \
   $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module testbench;
   logic             aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic             arvalid, arready, rvalid, rready, diff_mode, bandgap_sel, ground_sel, irq;
   logic [7:0]       awaddr, araddr;
   logic [31:0]      wdata, rdata, rv;
   logic [3:0]       wstrb;
   logic [1:0]       bresp, rresp, gain_sel, reference_select, br, rs;
   logic [9:0]       sample_code, res;
   logic [2:0]       pos_input, neg_input;
   logic [7:0][10:0] vin;
   logic [15:0]      seed, e;
   logic             la;
   int               n_errors, compares, k, ps, ng, gn, j;
   acf_top #(.CONV_CYCLES(8)) u_acf_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .sample_code(sample_code), .pos_input(pos_input),
      .neg_input(neg_input), .diff_mode(diff_mode), .gain_sel(gain_sel),
      .bandgap_sel(bandgap_sel), .ground_sel(ground_sel), .reference_select(reference_select),
      .irq(irq));
   acf_analog_model u_acf_analog_model (.pos_input(pos_input), .neg_input(neg_input),
      .diff_mode(diff_mode), .gain_sel(gain_sel), .bandgap_sel(bandgap_sel),
      .ground_sel(ground_sel), .reference_select(reference_select), .vin(vin),
      .sample_code(sample_code));
   initial begin
      aclk = 1'b0;
      forever #2 aclk = ~aclk;
   end
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   // result bytes as {high, low}
   function automatic logic [15:0] fmt(input logic [9:0] r, input logic l);
      return l ? {r, 6'h00} : {6'h00, r};
   endfunction
   task automatic end_of_test();
      if (n_errors == 0 && compares > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic fail();
      n_errors++;
      end_of_test();
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (i = 0; i < 50; i++) begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      br = bresp;
      bready <= 1'b0;
      if (i == 50) fail();
   endtask
   task automatic rd(input logic [7:0] a);
      int i;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (i = 0; i < 50; i++) begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      rv = rdata;
      rs = rresp;
      rready <= 1'b0;
      if (i == 50) fail();
   endtask
   task automatic idle();
      int i;
      for (i = 0; i < 50; i++) begin
         rd(8'h10);
         if (rv[1] === 1'b0) break;
      end
      if (i == 50) fail();
      res = sample_code;
   endtask
   task automatic shuffle();
      for (j = 0; j < 8; j++) begin
         seed = lfsr(seed);
         vin[j] <= seed[10:0];
      end
   endtask
   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
      wstrb = 4'hf;
      vin = '0;
      seed = 16'h0021;
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      rd(8'h00);
      `CHK("select reset", 32'h0, rv)
      rd(8'h18);
      `CHK("unmapped read", 2'b10, rs)
      wr(8'h18, 32'h1);
      `CHK("unmapped write", 2'b10, br)
      wr(8'h14, 32'h1);
      `CHK("mask write", 2'b00, br)
      for (k = 0; k < 32; k++) begin
         shuffle();
         la = seed[15];
         wr(8'h00, {24'h0, 2'(k), la, 5'(k)});
         wr(8'h0c, 32'h1);
         idle();
         ps = k < 8 ? k : k < 16 ? ((k - 8) / 4) * 2 + k % 2 : k < 24 ? k - 16 : k - 24;
         ng = k < 16 ? ((k - 8) / 4) * 2 : k < 24 ? 1 : 2;
         gn = (k < 8 || k >= 16) ? 0 : ((k / 2) % 2) ? 2 : 1;
         `CHK("mode", {1'(k >= 8 && k < 30), 1'(k == 30), 1'(k == 31)}, {diff_mode, bandgap_sel, ground_sel})
         if (k < 30) `CHK("pos", 3'(ps), pos_input)
         if (k >= 8 && k < 30) `CHK("neg gain", {3'(ng), 2'(gn)}, {neg_input, gain_sel})
         `CHK("reference", 2'(k), reference_select)
         e = fmt(res, la);
         rd(8'h04);
         `CHK("low byte", {24'h0, e[7:0]}, rv)
         rd(8'h08);
         `CHK("high byte", {24'h0, e[15:8]}, rv)
      end
      wr(8'h00, 32'h10);
      wr(8'h0c, 32'h1);
      wr(8'h00, 32'h38);
      `CHK("held channel", 3'h1, neg_input)
      idle();
      rd(8'h08);
      `CHK("left high", {24'h0, res[9:2]}, rv)
      wr(8'h00, 32'h18);
      rd(8'h08);
      `CHK("right high", {30'h0, res[9:8]}, rv)
      rd(8'h04);
      `CHK("right low", {24'h0, res[7:0]}, rv)
      shuffle();
      wr(8'h0c, 32'h1);
      repeat (20) @(posedge aclk);
      `CHK("new channel", 3'h2, neg_input)
      rd(8'h10);
      `CHK("held by lock", 2'b10, rv[1:0])
      rd(8'h08);
      `CHK("locked high", {30'h0, res[9:8]}, rv)
      idle();
      rd(8'h04);
      `CHK("released low", {24'h0, res[7:0]}, rv)
      rd(8'h08);
      `CHK("released high", {30'h0, res[9:8]}, rv)
      rd(8'h10);
      wr(8'h0c, 32'h1);
      for (j = 0; j < 60 && irq !== 1'b1; j++) @(posedge aclk);
      `CHK("irq raised", 1'b1, irq)
      rd(8'h10);
      `CHK("done flag", 1'b1, rv[0])
      repeat (2) @(posedge aclk);
      `CHK("irq cleared", 1'b0, irq)
      wr(8'h14, 32'h0);
      wr(8'h0c, 32'h1);
      repeat (20) @(posedge aclk);
      `CHK("irq masked", 1'b0, irq)
      rd(8'h10);
      `CHK("masked done", 1'b1, rv[0])
      end_of_test();
   end
endmodule
`default_nettype wire
